/* rtl/wdog_params.svh */
// Purpose: offsets, field positions, reset values and keys of the watchdog
// Assumes: included by its bare name from every design file that needs it
// Notes: definitions only
`ifndef WDOG_PARAMS_SVH
`define WDOG_PARAMS_SVH

// ****************************************************************
// register byte offsets on the bus
// ****************************************************************
`define OFS_CONTROL_HOLDING 8'h00
`define OFS_RELOAD_HOLDING 8'h04
`define OFS_FEED_FIRST 8'h08
`define OFS_FEED_SECOND 8'h0C
`define OFS_INTERRUPT_ENABLE 8'h10
`define OFS_STATUS 8'h14
`define OFS_USER_CONFIG 8'h18

// ****************************************************************
// control holding register fields
// ****************************************************************
`define CTRL_TAP_MSB 7
`define CTRL_TAP_LSB 5
`define CTRL_RUN_BIT 2
`define CTRL_FLAG_BIT 1
`define CTRL_CLKSEL_BIT 0
`define CTRL_RESET_VALUE 8'hE5
`define CTRL_WRITE_MASK 8'hE5
`define CTRL_SAFETY_FORCE 8'h05

// ****************************************************************
// other fields and values
// ****************************************************************
`define RELOAD_RESET_VALUE 8'hFF
`define CFG_RESET_EN_BIT 7
`define CFG_SAFETY_BIT 4
`define IEN_GLOBAL_BIT 7
`define IEN_TIMER_BIT 6
`define IEN_WRITE_MASK 8'hC0
`define IEN_RESET_VALUE 8'h00
`define FEED_FIRST_KEY 8'hA5
`define FEED_SECOND_KEY 8'h5A
`define PRESCALE_BASE_ONE 13'h0020

`endif

/* rtl/wdog_pkg.sv */
// Purpose: types shared by the watchdog design files
// Assumes: nothing
// Notes: every state of a module is one packed struct
package wdog_pkg;

    typedef enum logic [1:0] {
        FEED_IDLE,
        FEED_ARMED,
        FEED_CTRL_PEND
    } feed_state_e;

    typedef enum logic [2:0] {
        SEL_CONTROL,
        SEL_RELOAD,
        SEL_FEED_FIRST,
        SEL_FEED_SECOND,
        SEL_IEN,
        SEL_STATUS,
        SEL_CONFIG,
        SEL_NONE
    } reg_sel_e;

    typedef struct packed {
        logic [2:0] osc_sync;
        logic osc_level;
        logic pclk_phase;
        logic sel_cur;
        logic tick;
    } clk_src_s;

    typedef struct packed {
        logic [12:0] prescaler;
        logic [7:0] count;
        logic underflow;
    } counter_s;

    typedef struct packed {
        logic cfg_loaded;
        logic [7:0] user_config_byte;
        logic [7:0] wdog_control_holding;
        logic [7:0] control_active;
        logic [7:0] reload_holding;
        logic [7:0] reload_fed;
        logic overflow_flag;
        logic [7:0] interrupt_enable_reg;
        feed_state_e feed;
        logic control_once;
        logic reload_once;
        logic load;
        logic rst_active;
        logic rst_ticked;
        logic rst_cause;
        logic [2:0] stable_sync;
        logic stable_level;
        logic osc_restart;
        logic irq;
        logic [31:0] prdata;
        logic pslverr;
    } wdog_state_s;

endpackage

/* rtl/wdog_count_if.sv */
// Purpose: carries the counter controls between the top and the counter
// Assumes: one clock domain
// Notes: ctl side drives, cnt side answers
`timescale 1ns/1ps
`default_nettype none
interface wdog_count_if;
    logic tick;
    logic run;
    logic [2:0] tap;
    logic load;
    logic [7:0] load_val;
    logic [7:0] count;
    logic underflow;
    modport ctl (output tick, run, tap, load, load_val,
        input count, underflow);
    modport cnt (input tick, run, tap, load, load_val,
        output count, underflow);
endinterface
`default_nettype wire

/* rtl/wdog_clock_src.sv */
// Purpose: picks the watchdog count clock as a one-cycle tick
// Assumes: oscillator pin is asynchronous to mclk_i
// Notes: peripheral clock is mclk_i divided by two
`timescale 1ns/1ps
`default_nettype none
module wdog_clock_src
    import wdog_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic wdosc_i,
    input wire logic sel_i,
    input wire logic gate_i,
    output logic tick_o,
    output logic sel_active_o
);
    clk_src_s st;
    clk_src_s next;
    logic osc_rise;
    logic pclk_tick;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next = st;
        next.osc_sync = {st.osc_sync[1:0], wdosc_i};
        // change accepted only once the second and third stages agree
        if (st.osc_sync[1] == st.osc_sync[2]) begin
            next.osc_level = st.osc_sync[2];
        end
        osc_rise = next.osc_level & ~st.osc_level;
        next.pclk_phase = ~st.pclk_phase;
        // peripheral clock stops in power-down except while a watchdog reset is active, oscillator keeps going
        pclk_tick = st.pclk_phase & ~gate_i;
        // switch only on an edge of the new source: glitch-free, delayed
        if (sel_i != st.sel_cur) begin
            if (sel_i ? osc_rise : pclk_tick) begin
                next.sel_cur = sel_i;
            end
        end
        next.tick = st.sel_cur ? osc_rise : pclk_tick;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '{osc_sync: 3'h0, osc_level: 1'b0, pclk_phase: 1'b0,
                sel_cur: 1'b1, tick: 1'b0};
        end else begin
            st <= next;
        end
    end

    assign tick_o = st.tick;
    assign sel_active_o = st.sel_cur;
endmodule
`default_nettype wire

/* rtl/wdog_down_counter.sv */
// Purpose: 13-bit prescaler and 8-bit down counter
// Assumes: tick is a one-cycle enable of the chosen count clock
// Notes: load wins over counting in the same cycle
`timescale 1ns/1ps
`default_nettype none
`include "wdog_params.svh"
module wdog_down_counter
    import wdog_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    wdog_count_if.cnt cnt_if
);
    counter_s st;
    counter_s next;

    function automatic logic tap_hit(input logic [12:0] pre,
        input logic [2:0] tap);
        logic [12:0] mask;
        mask = (`PRESCALE_BASE_ONE << tap) - 13'h0001;
        return (pre & mask) == mask;
    endfunction

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next = st;
        next.underflow = 1'b0;
        if (cnt_if.load) begin
            next.prescaler = 13'h0000;
            next.count = cnt_if.load_val;
        end else if (cnt_if.run && cnt_if.tick) begin
            next.prescaler = st.prescaler + 13'h0001;
            // period of the tap is 2 to the power of 5 plus select
            if (tap_hit(st.prescaler, cnt_if.tap)) begin
                if (st.count == 8'h00) begin
                    next.underflow = 1'b1;
                    next.count = cnt_if.load_val;
                end else begin
                    next.count = st.count - 8'h01;
                end
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '{prescaler: 13'h0000, count: `RELOAD_RESET_VALUE,
                underflow: 1'b0};
        end else begin
            st <= next;
        end
    end

    assign cnt_if.count = st.count;
    assign cnt_if.underflow = st.underflow;
endmodule
`default_nettype wire

/* rtl/wdog_timer.sv */
// Purpose: watchdog timer with feed sequence, APB register slave
// Assumes: rst_n_i is the power-on reset only
// Notes: zero-wait APB; other chip resets arrive on other_reset_i
//
// Overview of operation
// - underflow with reset enabled asserts the watchdog reset
// - watchdog state cleared only by power-on reset
// - config bit 7 lets underflow reset the device
// - timer runs after any reset whatever the config
// - control bit 2 starts and stops the timer, set after reset
// - without reset, underflow raises interrupt through enable bits 6 and 7
// - reset-enable clear disables reset and ignores safety bit
// - reset on, safety off: software picks clock source
// - reset and safety on force oscillator, run, single writes
// - 13-bit prescaler tap decrements an 8-bit down counter
// - clock select picks source, change takes effect later
// - with reset on, holding values act only after a feed
// - watchdog reset lasts at least one watchdog clock
// - in power-down, reset restarts oscillator, waits until stable
// - feed copies control and reload holding into active copies
// - reads between feed writes allowed, other writes break it
// - wrong feed values or order cause an immediate reset
// - control write not followed at once by feed causes reset
// - timeout is 2^(5+tap) times (reload+1) plus one clocks
// - top three control bits select prescaler tap 0 to 7
// - timer mode copies control every cycle, reload needs feed
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "wdog_params.svh"
module wdog_timer
    import wdog_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [7:0] user_config_i,
    input wire logic wdosc_i,
    input wire logic other_sfr_write_i,
    input wire logic other_reset_i,
    input wire logic power_down_i,
    input wire logic osc_stable_i,
    output logic wdog_reset_o,
    output logic osc_restart_o,
    output logic timer_irq_o
);
    wdog_state_s st;
    wdog_state_s next;
    // counter controls travel as one bundle
    wdog_count_if cnt_if();
    logic src_tick;
    logic src_sel;
    logic wr;
    logic setup;
    reg_sel_e sel;
    logic [7:0] wdata;
    logic reset_on_underflow_en;
    logic safety_enable;
    logic fault;
    logic feed_done;
    logic release_rst;

    // one decode shared by the write and read paths
    function automatic reg_sel_e decode(input logic [7:0] addr);
        reg_sel_e s;
        unique case (addr)
            `OFS_CONTROL_HOLDING: s = SEL_CONTROL;
            `OFS_RELOAD_HOLDING: s = SEL_RELOAD;
            `OFS_FEED_FIRST: s = SEL_FEED_FIRST;
            `OFS_FEED_SECOND: s = SEL_FEED_SECOND;
            `OFS_INTERRUPT_ENABLE: s = SEL_IEN;
            `OFS_STATUS: s = SEL_STATUS;
            `OFS_USER_CONFIG: s = SEL_CONFIG;
            default: s = SEL_NONE;
        endcase
        return s;
    endfunction

    // ****************************************************************
    // clock source and counter
    // ****************************************************************
    wdog_clock_src u_clock_src (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .wdosc_i(wdosc_i),
        .sel_i(st.control_active[`CTRL_CLKSEL_BIT]),
        .gate_i(power_down_i & ~st.rst_active),
        .tick_o(src_tick),
        .sel_active_o(src_sel)
    );

    wdog_down_counter u_down_counter (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .cnt_if(cnt_if)
    );

    assign cnt_if.tick = src_tick;
    assign cnt_if.run = st.control_active[`CTRL_RUN_BIT];
    assign cnt_if.tap = st.control_active[`CTRL_TAP_MSB:`CTRL_TAP_LSB];
    assign cnt_if.load = st.load;
    assign cnt_if.load_val = st.reload_fed;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next = st;
        wr = psel_i & penable_i & pwrite_i;
        setup = psel_i & ~penable_i;
        sel = decode(paddr_i);
        wdata = pwdata_i[7:0];
        fault = 1'b0;
        feed_done = 1'b0;
        release_rst = 1'b0;
        next.load = 1'b0;

        // non-volatile bits are caught once, after power-on release
        if (!st.cfg_loaded) begin
            next.user_config_byte = user_config_i;
            next.cfg_loaded = 1'b1;
        end
        reset_on_underflow_en = st.user_config_byte[`CFG_RESET_EN_BIT];
        // safety bit means nothing without reset enable
        safety_enable = reset_on_underflow_en &
            st.user_config_byte[`CFG_SAFETY_BIT];

        next.stable_sync = {st.stable_sync[1:0], osc_stable_i};
        if (st.stable_sync[1] == st.stable_sync[2]) begin
            next.stable_level = st.stable_sync[2];
        end

        // any outside register write splits a started sequence
        if (other_sfr_write_i && st.feed != FEED_IDLE) begin
            fault = 1'b1;
        end

        // writes commit at the access edge only
        if (wr) begin
            // only the expected next write may follow
            if (st.feed == FEED_ARMED && sel != SEL_FEED_SECOND) begin
                fault = 1'b1;
            end
            if (st.feed == FEED_CTRL_PEND && sel != SEL_FEED_FIRST) begin
                fault = 1'b1;
            end
            unique case (sel)
                SEL_CONTROL: begin
                    if (!(safety_enable && st.control_once)) begin
                        next.wdog_control_holding =
                            wdata & `CTRL_WRITE_MASK;
                        next.overflow_flag = wdata[`CTRL_FLAG_BIT];
                        next.control_once = st.control_once | safety_enable;
                    end
                    if (reset_on_underflow_en) begin
                        next.feed = FEED_CTRL_PEND;
                    end
                end
                SEL_RELOAD: begin
                    if (!(safety_enable && st.reload_once)) begin
                        next.reload_holding = wdata;
                        next.reload_once = st.reload_once | safety_enable;
                    end
                end
                SEL_FEED_FIRST: begin
                    if (wdata == `FEED_FIRST_KEY &&
                        st.feed != FEED_ARMED) begin
                        next.feed = FEED_ARMED;
                    end else begin
                        fault = 1'b1;
                    end
                end
                SEL_FEED_SECOND: begin
                    if (st.feed == FEED_ARMED &&
                        wdata == `FEED_SECOND_KEY) begin
                        feed_done = 1'b1;
                    end else begin
                        fault = 1'b1;
                    end
                end
                SEL_IEN: begin
                    next.interrupt_enable_reg = wdata & `IEN_WRITE_MASK;
                end
                SEL_STATUS: begin
                end
                SEL_CONFIG: begin
                end
                SEL_NONE: begin
                end
            endcase
        end

        if (fault || feed_done) begin
            next.feed = FEED_IDLE;
        end
        // a fault in the same cycle cancels the reload
        if (feed_done && !fault) begin
            next.reload_fed = st.reload_holding;
            next.load = 1'b1;
            if (reset_on_underflow_en) begin
                next.control_active = st.wdog_control_holding;
            end
        end
        // timer mode: holding acts at once, no feed
        if (!reset_on_underflow_en) begin
            next.control_active = next.wdog_control_holding;
        end

        // timeout flag: hardware set wins over a software clear
        if (cnt_if.underflow) begin
            next.overflow_flag = 1'b1;
        end

        // watchdog reset: further causes ignored while it is active
        if (reset_on_underflow_en && (fault || cnt_if.underflow) &&
            !st.rst_active) begin
            next.rst_active = 1'b1;
            next.rst_ticked = 1'b0;
            next.rst_cause = 1'b1;
        end
        if (st.rst_active) begin
            if (src_tick) begin
                next.rst_ticked = 1'b1;
            end
            // power-down: hold until the oscillator reports stable
            if (st.rst_ticked && (!power_down_i || st.stable_level)) begin
                next.rst_active = 1'b0;
                release_rst = 1'b1;
            end
        end
        // own and other resets are not power-on: only the run bit is restored and the feed sequence cleared
        if (release_rst || other_reset_i) begin
            next.wdog_control_holding[`CTRL_RUN_BIT] = 1'b1;
            next.control_active[`CTRL_RUN_BIT] = 1'b1;
            next.feed = FEED_IDLE;
        end
        // only wake the oscillator while the core sleeps
        next.osc_restart = next.rst_active & power_down_i;

        // forcing comes last so no path can undo it
        if (safety_enable) begin
            next.wdog_control_holding =
                next.wdog_control_holding | `CTRL_SAFETY_FORCE;
            next.control_active =
                next.control_active | `CTRL_SAFETY_FORCE;
        end

        // level irq, cleared through the flag
        next.irq = next.overflow_flag & ~reset_on_underflow_en &
            st.interrupt_enable_reg[`IEN_TIMER_BIT] &
            st.interrupt_enable_reg[`IEN_GLOBAL_BIT];

        // read data and error are settled in the setup phase
        if (setup) begin
            next.pslverr = (sel == SEL_NONE);
            unique case (sel)
                SEL_CONTROL: begin
                    next.prdata = {24'h000000, st.wdog_control_holding};
                    next.prdata[`CTRL_FLAG_BIT] = st.overflow_flag;
                end
                SEL_RELOAD: begin
                    next.prdata = {24'h000000, st.reload_holding};
                end
                SEL_IEN: begin
                    next.prdata = {24'h000000, st.interrupt_enable_reg};
                end
                // sticky cause, source and count for software
                SEL_STATUS: begin
                    next.prdata = {13'h0000, st.feed != FEED_IDLE,
                        st.rst_cause, src_sel, st.control_active,
                        cnt_if.count};
                end
                SEL_CONFIG: begin
                    next.prdata = {24'h000000, st.user_config_byte};
                end
                SEL_FEED_FIRST: begin
                    next.prdata = 32'h00000000;
                end
                SEL_FEED_SECOND: begin
                    next.prdata = 32'h00000000;
                end
                SEL_NONE: begin
                    next.prdata = 32'h00000000;
                end
            endcase
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '{
                cfg_loaded: 1'b0,
                user_config_byte: 8'h00,
                wdog_control_holding: `CTRL_RESET_VALUE,
                control_active: `CTRL_RESET_VALUE,
                reload_holding: `RELOAD_RESET_VALUE,
                reload_fed: `RELOAD_RESET_VALUE,
                overflow_flag: 1'b0,
                interrupt_enable_reg: `IEN_RESET_VALUE,
                feed: FEED_IDLE,
                control_once: 1'b0,
                reload_once: 1'b0,
                load: 1'b0,
                rst_active: 1'b0,
                rst_ticked: 1'b0,
                rst_cause: 1'b0,
                stable_sync: 3'h0,
                stable_level: 1'b0,
                osc_restart: 1'b0,
                irq: 1'b0,
                prdata: 32'h00000000,
                pslverr: 1'b0
            };
        end else begin
            st <= next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // zero wait states: every access is one cycle
    assign pready_o = 1'b1;
    assign prdata_o = st.prdata;
    assign pslverr_o = st.pslverr;
    assign wdog_reset_o = st.rst_active;
    assign osc_restart_o = st.osc_restart;
    assign timer_irq_o = st.irq;
endmodule
`default_nettype wire

/* tb/wdog_timer_chk.sv */
// Purpose: port-level assertions for wdog_timer
// Assumes: config byte changes only while rst_n_i is low
// Notes: bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module wdog_timer_chk (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [7:0] user_config_i,
    input wire logic wdosc_i,
    input wire logic other_sfr_write_i,
    input wire logic other_reset_i,
    input wire logic power_down_i,
    input wire logic osc_stable_i,
    input wire logic wdog_reset_o,
    input wire logic osc_restart_o,
    input wire logic timer_irq_o
);
    // ****
    // checks
    // ****
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    logic wr;
    logic rd;
    logic wd;
    assign wr = psel_i && penable_i && pwrite_i;
    assign rd = psel_i && penable_i && !pwrite_i;
    assign wd = user_config_i[7];
    irq_timer_only_a: assert property (
        timer_irq_o |-> !wd) else $error("irq in reset mode");
    reset_needs_cfg_a: assert property (
        wdog_reset_o |-> wd) else $error("reset in timer mode");
    reset_hold_a: assert property (
        $rose(wdog_reset_o) |=> wdog_reset_o) else $error("reset too short");
    reset_release_a: assert property (
        $rose(wdog_reset_o) |-> ##[2:200] !wdog_reset_o)
        else $error("reset never released");
    bad_first_a: assert property (
        wr && paddr_i == 8'h08 && pwdata_i[7:0] != 8'hA5 && wd
        |=> wdog_reset_o) else $error("bad first key ignored");
    bad_second_a: assert property (
        wr && paddr_i == 8'h0C && pwdata_i[7:0] != 8'h5A && wd
        |=> wdog_reset_o) else $error("bad second key ignored");
    safety_force_a: assert property (
        rd && paddr_i == 8'h14 && wd && user_config_i[4]
        |-> prdata_o[10] && prdata_o[8]) else $error("safety not forced");
    osc_restart_pd_a: assert property (
        wdog_reset_o && $past(power_down_i) |-> osc_restart_o)
        else $error("oscillator not restarted");
    cover property ($rose(timer_irq_o));
    cover property ($rose(wdog_reset_o));
    cover property (osc_restart_o);
endmodule
`default_nettype wire

/* tb/wdog_timer_tb.sv */
// Purpose: self-checking bench for wdog_timer
// Assumes: config byte set only while in reset
// Notes: reads noted in a queue, checked by a monitor
`timescale 1ns/1ps
`default_nettype none
module wdog_timer_tb;
    // ****
    // bench
    // ****
    logic mclk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0;
    logic pwrite_i = 0, wdosc_i = 0, other_sfr_write_i = 0;
    logic other_reset_i = 0, power_down_i = 0, osc_stable_i = 1;
    logic [7:0] paddr_i = 8'h00, user_config_i = 8'h00, r;
    logic [31:0] pwdata_i = 32'h0, prdata_o;
    logic pready_o, pslverr_o, wdog_reset_o, osc_restart_o, timer_irq_o;
    logic [32:0] exp_q[$], msk_q[$];
    int miscompares = 0, total_checks = 0, cyc = 0, n;
    int unsigned seed = 45547;
    wdog_timer u_dut (.mclk_i, .rst_n_i, .paddr_i, .psel_i, .penable_i,
        .pwrite_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
        .user_config_i, .wdosc_i, .other_sfr_write_i, .other_reset_i,
        .power_down_i, .osc_stable_i, .wdog_reset_o, .osc_restart_o,
        .timer_irq_o);
    initial forever #25 mclk_i = ~mclk_i;
    // free oscillator, unrelated rate to the peripheral tick
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc % 12 == 0) wdosc_i <= ~wdosc_i;
    end
    always @(posedge mclk_i) begin
        if (cyc == 40000) begin
            miscompares++;
            report_and_stop();
        end
    end
    always @(posedge mclk_i) begin
        if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) begin
            chk({pslverr_o, prdata_o} & msk_q.pop_front(), exp_q.pop_front());
        end
    end
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        psel_i <= 1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= {24'h0, d};
        @(posedge mclk_i);
        penable_i <= 1;
        @(posedge mclk_i);
        while (pready_o !== 1'b1) @(posedge mclk_i);
        psel_i <= 0;
        penable_i <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] m, e);
        msk_q.push_back(m);
        exp_q.push_back(e);
        apb(0, a, 8'h00);
    endtask
    task automatic wait_for(ref logic s, input logic v, input int lim);
        n = 0;
        @(negedge mclk_i);
        while (s !== v && n < lim) begin
            @(negedge mclk_i);
            n++;
        end
        chk(s, v);
    endtask
    task automatic por(input logic [7:0] cfg);
        rst_n_i <= 0;
        user_config_i <= cfg;
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1;
        @(posedge mclk_i);
    endtask
    task automatic feed();
        wr(8'h08, 8'hA5);
        wr(8'h0C, 8'h5A);
    endtask
    // a fault reset is a level, so wait for its release before the next one
    task automatic fault(input logic [7:0] a, input logic [7:0] d);
        wr(a, d);
        wait_for(wdog_reset_o, 1, 4);
        wait_for(wdog_reset_o, 0, 300);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        por(8'h00);
        rd(8'h00, 33'hFF, 33'hE5);
        rd(8'h04, 33'hFF, 33'hFF);
        rd(8'h1C, 33'h100000000, 33'h100000000);
        r = xs() & 8'h03;
        wr(8'h04, r);
        wr(8'h10, 8'hC0);
        wr(8'h00, 8'h04);
        feed();
        rd(8'h14, 33'hFF, {25'h0, r});
        wait_for(timer_irq_o, 1, 600);
        chk(n > (r + 1) * 64 - 16 && n < (r + 1) * 64 + 16, 1);
        chk(wdog_reset_o, 0);
        rd(8'h00, 33'h02, 33'h02);
        wr(8'h10, 8'h00);
        wait_for(timer_irq_o, 0, 3);
        wr(8'h08, 8'h11);
        por(8'h80);
        wr(8'h04, 8'h01);
        wr(8'h00, 8'h04);
        wr(8'h08, 8'hA5);
        rd(8'h14, 33'h40000, 33'h40000);
        wr(8'h0C, 8'h5A);
        rd(8'h14, 33'hFFFF, 33'h0401);
        wait_for(wdog_reset_o, 1, 300);
        wait_for(wdog_reset_o, 0, 300);
        rd(8'h00, 33'h04, 33'h04);
        rd(8'h04, 33'hFF, 33'h01);
        wr(8'h04, 8'hFF);
        feed();
        power_down_i <= 1;
        osc_stable_i <= 0;
        wr(8'h08, 8'h00);
        wait_for(wdog_reset_o, 1, 4);
        chk(osc_restart_o, 1);
        repeat (40) @(negedge mclk_i);
        chk(wdog_reset_o, 1);
        @(posedge mclk_i);
        osc_stable_i <= 1;
        wait_for(wdog_reset_o, 0, 300);
        @(posedge mclk_i);
        power_down_i <= 0;
        fault(8'h0C, 8'h33);
        wr(8'h08, 8'hA5);
        other_sfr_write_i <= 1;
        @(posedge mclk_i);
        other_sfr_write_i <= 0;
        wait_for(wdog_reset_o, 1, 4);
        wait_for(wdog_reset_o, 0, 300);
        wr(8'h00, 8'h04);
        fault(8'h04, 8'h03);
        @(posedge mclk_i);
        other_reset_i <= 1;
        @(posedge mclk_i);
        other_reset_i <= 0;
        rd(8'h04, 33'hFF, 33'h03);
        por(8'h90);
        wr(8'h00, 8'h00);
        feed();
        rd(8'h14, 33'h10500, 33'h10500);
        wr(8'h04, 8'h10);
        wr(8'h04, 8'h20);
        rd(8'h04, 33'hFF, 33'h10);
        report_and_stop();
    end
endmodule
bind wdog_timer wdog_timer_chk u_chk (.mclk_i, .rst_n_i, .paddr_i, .psel_i,
    .penable_i, .pwrite_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .user_config_i, .wdosc_i, .other_sfr_write_i, .other_reset_i,
    .power_down_i, .osc_stable_i, .wdog_reset_o, .osc_restart_o,
    .timer_irq_o);
`default_nettype wire
